// ===== hw/sdram_core.sv
// Synchronous DRAM core: command decode, mode register, bursts, refresh, power
// Operation
// - Burst length from mode bits 2..0: 1,2,4,8 words, 7 full page.
// - Mode bit 3 picks sequential (0) or interleaved (1) burst order.
// - Sequential bursts increment the column, wrapping in 8 bits.
// - Interleaved bursts invert low start column bits where word index is one.
// - Read latency code 2 or 3 gives clocks from read to first data.
// - Mode bit 9 set makes every write a single word.
// - Selected all-high command is a no-operation.
// - Burst stop ends a burst that runs without auto precharge.
// - After burst stop, read data continues for one clock less than the read latency.
// - Chip select high ignores the command and address pins.
// - Auto refresh refreshes the counter row, then advances the counter.
// - Self refresh ignores all but clock enable and refreshes internally.
// - Clock enable low in a burst freezes state from the next cycle.
// - Clock enable low with banks idle enters power-down.
// - Clock enable high resumes the internal clock or leaves power-down.
// - Mask high blocks a written word and disables read output.
// - Mode register set loads bank and address pins when banks idle.
// - Mask acts on read output two clocks after it is sampled.
module sdram_core #(
    parameter int SR_TICK = sdram_pkg::SR_TICK_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sdram_pkg::BANK_W-1:0] ba,
    input wire logic [sdram_pkg::ADDR_W-1:0] addr,
    // Data pins
    input wire logic dqm,
    input wire logic [sdram_pkg::DATA_W-1:0] dq_in,
    output logic [sdram_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    // Receiver stall for read data
    input wire logic dq_ready,
    // Status
    output sdram_pkg::mode_t mode_reg,
    output logic [sdram_pkg::ROW_W-1:0] refresh_row,
    output sdram_pkg::pwr_t pwr_state,
    output logic suspended,
    output logic burst_busy
);
    // Pin decode, chip select high gives deselect
    function automatic sdram_pkg::cmd_t decode(input logic cs, r, c, w);
        sdram_pkg::cmd_t res;
        res = sdram_pkg::cmd_mrs;
        if (cs)
            res = sdram_pkg::cmd_desel;
        else
            case ({r, c, w})
                3'h7: res = sdram_pkg::cmd_nop;
                3'h3: res = sdram_pkg::cmd_act;
                3'h5: res = sdram_pkg::cmd_read;
                3'h4: res = sdram_pkg::cmd_write;
                3'h6: res = sdram_pkg::cmd_stop;
                3'h2: res = sdram_pkg::cmd_pre;
                3'h1: res = sdram_pkg::cmd_ref;
                default: res = sdram_pkg::cmd_mrs;
            endcase
        return res;
    endfunction

    // Words in a burst; single-word writes override the length
    function automatic logic [8:0] burst_words(input logic [2:0] code, input logic single);
        logic [8:0] n;
        n = 9'h1;
        if (!single)
            case (code)
                sdram_pkg::BL_2: n = 9'h2;
                sdram_pkg::BL_4: n = 9'h4;
                sdram_pkg::BL_8: n = 9'h8;
                sdram_pkg::BL_FULL: n = sdram_pkg::PAGE_WORDS;
                default: n = 9'h1;
            endcase
        return n;
    endfunction

    // Burst state
    logic bst_read;
    logic bst_autopre;
    logic [1:0] bst_bank;
    logic [7:0] bst_start;
    logic [7:0] bst_k;
    logic [8:0] bst_words;
    logic [3:0] bank_open;
    logic dqm_q;
    logic [11:0] sr_cnt;
    // Read pipeline and two-entry output buffer
    logic pv0;
    logic pv1;
    logic [31:0] pd0;
    logic [31:0] pd1;
    logic [1:0] buf_cnt;
    sdram_pkg::rd_word_t e0;
    sdram_pkg::rd_word_t e1;
    logic [31:0] mem [0:1023];

    // Command and enables
    wire sdram_pkg::cmd_t cmd = decode(cs_n, ras_n, cas_n, we_n);
    wire lat3 = mode_reg.latency == sdram_pkg::CL_3;
    wire tap_v = lat3 ? pv1 : pv0;
    wire [31:0] tap_d = lat3 ? pd1 : pd0;
    wire stall = tap_v && buf_cnt == 2'h2;
    wire adv = pwr_state == sdram_pkg::pwr_run && !suspended && !stall;
    wire all_idle = bank_open == 4'h0 && !burst_busy;
    wire is_rd = cmd == sdram_pkg::cmd_read;
    wire is_wr = cmd == sdram_pkg::cmd_write;
    wire is_pre = cmd == sdram_pkg::cmd_pre;
    wire is_ref = cmd == sdram_pkg::cmd_ref;

    // Burst start, stop and stepping
    wire start = adv && (is_rd || is_wr);
    wire [8:0] words = burst_words(mode_reg.burst_len, is_wr && mode_reg.write_burst_mode);
    wire stop_hit = adv && cmd == sdram_pkg::cmd_stop && burst_busy && !bst_autopre;
    wire cont = adv && burst_busy && !start && !stop_hit && !is_pre;
    wire burst_end = cont && !bst_words[8] && {1'b0, bst_k} == bst_words - 9'h1;
    wire [7:0] col_seq = bst_start + bst_k;
    wire [7:0] col_int = bst_start ^ {5'h0, bst_k[2:0]};
    wire [7:0] k_col = mode_reg.burst_order_select ? col_int : col_seq;
    wire [9:0] acc_idx = start ? {ba, addr[7:0]} : {bst_bank, k_col};
    wire acc_rd = start ? is_rd : cont && bst_read;
    wire acc_wr = start ? is_wr : cont && !bst_read;
    wire ap_close = burst_end && bst_autopre;
    wire ap_now = start && words == 9'h1 && addr[sdram_pkg::AP_POS];
    wire sr_tick = pwr_state == sdram_pkg::pwr_self && sr_cnt == 12'(SR_TICK - 1);

    // Buffer moves; mask sampled two edges before the data edge
    wire push = adv && tap_v;
    wire pop = buf_cnt != 2'h0 && dq_ready;
    wire sdram_pkg::rd_word_t in_w = '{mask: dqm_q, data: tap_d};
    wire [1:0] cnt_nx = buf_cnt + {1'b0, push} - {1'b0, pop};
    wire sdram_pkg::rd_word_t e0_nx = pop ? (buf_cnt == 2'h2 ? e1 : in_w)
                                          : (buf_cnt == 2'h0 ? in_w : e0);
    wire sdram_pkg::rd_word_t e1_nx = (push && cnt_nx == 2'h2) ? in_w : e1;

    // Clock enable sampled once: masks the following cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            suspended <= 1'b0;
        else
            suspended <= !cke;
        dqm_q <= dqm;
    end

    // Mode register load
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            mode_reg <= sdram_pkg::MODE_RST;
        else if (adv && cmd == sdram_pkg::cmd_mrs && all_idle)
            mode_reg <= {ba, addr};
    end

    // Burst sequencer
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            burst_busy <= 1'b0;
            bst_read <= 1'b0;
            bst_autopre <= 1'b0;
            bst_bank <= 2'h0;
            bst_start <= 8'h0;
            bst_k <= 8'h0;
            bst_words <= 9'h1;
        end
        else if (start)
        begin
            burst_busy <= words != 9'h1;
            bst_read <= is_rd;
            bst_autopre <= addr[sdram_pkg::AP_POS];
            bst_bank <= ba;
            bst_start <= addr[7:0];
            bst_k <= 8'h1;
            bst_words <= words;
        end
        else if (stop_hit || (adv && is_pre))
            burst_busy <= 1'b0;
        else if (cont)
        begin
            bst_k <= bst_k + 8'h1;
            if (burst_end)
                burst_busy <= 1'b0;
        end
    end

    // Open banks, closed by precharge or auto precharge
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            bank_open <= 4'h0;
        else if (adv)
        begin
            if (cmd == sdram_pkg::cmd_act)
                bank_open[ba] <= 1'b1;
            else if (is_pre && addr[sdram_pkg::AP_POS])
                bank_open <= 4'h0;
            else if (is_pre)
                bank_open[ba] <= 1'b0;
            else if (ap_now)
                bank_open[ba] <= 1'b0;
            if (ap_close)
                bank_open[bst_bank] <= 1'b0;
        end
    end

    // Array: masked words are not written
    always_ff @(posedge core_clk)
    begin
        if (acc_wr && !dqm)
            mem[acc_idx] <= dq_in;
    end

    // Read pipeline, tap chosen by latency; a stop leaves fetched words flowing
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pv0 <= 1'b0;
            pv1 <= 1'b0;
        end
        else if (adv)
        begin
            pv0 <= acc_rd;
            pv1 <= pv0;
        end
        if (adv)
        begin
            pd0 <= mem[acc_idx];
            pd1 <= pd0;
        end
    end

    // Output buffer; the pin driver stays off for masked words
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            buf_cnt <= 2'h0;
            dq_oe_n <= 1'b1;
        end
        else
        begin
            buf_cnt <= cnt_nx;
            dq_oe_n <= !(cnt_nx != 2'h0 && !e0_nx.mask);
        end
        e0 <= e0_nx;
        e1 <= e1_nx;
        dq_out <= e0_nx.data;
    end

    // Power state: power-down, self refresh, run
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            pwr_state <= sdram_pkg::pwr_run;
        else
            case (pwr_state)
                sdram_pkg::pwr_run:
                    if (adv && is_ref && !cke && all_idle)
                        pwr_state <= sdram_pkg::pwr_self;
                    else if (!cke && all_idle)
                        pwr_state <= sdram_pkg::pwr_down;
                sdram_pkg::pwr_down:
                    if (cke)
                        pwr_state <= sdram_pkg::pwr_run;
                sdram_pkg::pwr_self:
                    if (cke)
                        pwr_state <= sdram_pkg::pwr_run;
                default:
                    pwr_state <= sdram_pkg::pwr_run;
            endcase
    end

    // Refresh row counter: auto refresh and self refresh pacing
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            refresh_row <= 12'h0;
            sr_cnt <= 12'h0;
        end
        else
        begin
            if ((adv && is_ref && cke && all_idle) || sr_tick)
                refresh_row <= refresh_row + 12'h1;
            if (pwr_state != sdram_pkg::pwr_self || sr_tick)
                sr_cnt <= 12'h0;
            else
                sr_cnt <= sr_cnt + 12'h1;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    mrs_load_a: assert property (adv && cmd == sdram_pkg::cmd_mrs && all_idle |=>
        mode_reg == $past({ba, addr})) else $error("mode register not loaded");
    bl8_len_a: assert property (start && is_rd && mode_reg.burst_len == sdram_pkg::BL_8
        && dq_ready ##1 (cont && !is_pre)[*6] |=> burst_busy && (burst_end || !cont))
        else $error("eight word burst length wrong");
    seq_step_a: assert property (cont && !mode_reg.burst_order_select && !burst_end |=>
        k_col == $past(k_col) + 8'h1) else $error("sequential column step wrong");
    intl_addr_a: assert property (burst_busy && mode_reg.burst_order_select |->
        acc_idx[7:0] == (bst_start ^ {5'h0, bst_k[2:0]}) || start)
        else $error("interleaved column wrong");
    cl_first_a: assert property (start && is_rd && buf_cnt == 2'h0 && !lat3 && !suspended
        ##1 adv |=> buf_cnt != 2'h0) else $error("first read word late");
    single_wr_a: assert property (start && is_wr && mode_reg.write_burst_mode |=>
        !burst_busy) else $error("single write burst kept running");
    nop_hold_a: assert property (adv && !burst_busy && (cmd == sdram_pkg::cmd_nop
        || cmd == sdram_pkg::cmd_desel) |=> $stable(bank_open) && $stable(mode_reg))
        else $error("idle command changed state");
    stop_end_a: assert property (stop_hit |=> !burst_busy)
        else $error("burst stop ignored");
    ref_step_a: assert property (adv && is_ref && cke && all_idle |=>
        refresh_row == $past(refresh_row) + 12'h1) else $error("refresh row not advanced");
    susp_hold_a: assert property (suspended && pwr_state == sdram_pkg::pwr_run |=>
        $stable(bst_k) && $stable(pv0)) else $error("state moved while suspended");
    oe_mask_a: assert property (push && dqm_q |=> dq_oe_n || buf_cnt == 2'h2)
        else $error("masked read word driven");

    rd_burst_c: cover property (start && is_rd ##1 burst_busy [*3]);
    stop_c: cover property (stop_hit && bst_read);
    self_ref_c: cover property (pwr_state == sdram_pkg::pwr_self ##[1:8] sr_tick);
    buf_full_c: cover property (buf_cnt == 2'h2 && !dq_ready);
endmodule

// ===== hw/sdram_pkg.sv
// Shared constants and types for the synchronous DRAM core
package sdram_pkg;
    // Array geometry
    localparam int COL_W = 8;
    localparam int BANK_W = 2;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int ROW_W = 12;
    localparam int AP_POS = 10;
    // Burst length codes and the full page word count
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [8:0] PAGE_WORDS = 9'h100;
    // Read latency codes
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;
    // Self refresh pacing: every row once per refresh period
    localparam longint REFRESH_NS = 64000000;
    localparam longint REFRESH_ROWS = 4096;
    localparam longint CLK_NS = 5;
    localparam int SR_TICK_CYC = int'(REFRESH_NS / REFRESH_ROWS / CLK_NS);
    // Mode register layout, bank selects on top
    typedef struct packed {
        logic [1:0] bank_rsv;
        logic [1:0] reserved_bits;
        logic write_burst_mode;
        logic [1:0] test_mode;
        logic [2:0] latency;
        logic burst_order_select;
        logic [2:0] burst_len;
    } mode_t;
    localparam mode_t MODE_RST = '0;
    // Decoded commands
    typedef enum logic [3:0] {
        cmd_desel, cmd_nop, cmd_act, cmd_read, cmd_write,
        cmd_stop, cmd_pre, cmd_ref, cmd_mrs
    } cmd_t;
    // Power states
    typedef enum logic [1:0] {pwr_run, pwr_down, pwr_self} pwr_t;
    // Read word on its way to the pins
    typedef struct packed {
        logic mask;
        logic [DATA_W-1:0] data;
    } rd_word_t;
endpackage

// ===== tb/ctrl_model.sv
// Controller model: drives commands, mask, write data and read acceptance
module ctrl_model #(
    parameter int T_RC = 14,
    parameter int T_CAC_NS = 10
) (
    // Clock
    input wire logic core_clk,
    // Command pins
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [11:0] addr,
    // Data side
    output logic dqm,
    output logic [31:0] dq_in,
    output logic dq_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Least latency whose clocks cover the column access time
    localparam logic [2:0] CL_MIN = 3'((T_CAC_NS + sdram_pkg::CLK_NS - 1) / sdram_pkg::CLK_NS);
    // Idle pins from time zero
    initial
    begin
        {cke, dq_ready, dqm} = 3'h6;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        {ba, addr} = 14'h0;
        dq_in = 32'h0;
    end
    // One command for one edge; an undriven data bus toggles every cycle
    task automatic cmd(sdram_pkg::cmd_t c, logic [13:0] p = 14'h0, logic m = 1'b0,
                       logic dv = 1'b0, logic [31:0] d = 32'h0);
        logic [3:0] e;
        case (c)
            sdram_pkg::cmd_desel: e = 4'h8;
            sdram_pkg::cmd_act: e = 4'h3;
            sdram_pkg::cmd_read: e = 4'h5;
            sdram_pkg::cmd_write: e = 4'h4;
            sdram_pkg::cmd_stop: e = 4'h6;
            sdram_pkg::cmd_pre: e = 4'h2;
            sdram_pkg::cmd_ref: e = 4'h1;
            sdram_pkg::cmd_mrs: e = 4'h0;
            default: e = 4'h7;
        endcase
        {cs_n, ras_n, cas_n, we_n} <= e;
        {ba, addr} <= p;
        dqm <= m;
        dq_in <= dv ? d : ~dq_in;
        @(posedge core_clk);
    endtask
    // Clock enable and read acceptance for the following edges
    task automatic pins(logic ck, logic rdy);
        cke <= ck;
        dq_ready <= rdy;
    endtask
    // Idle edges
    task automatic nop(int n);
        repeat (n) cmd(sdram_pkg::cmd_nop);
    endtask
    // Mode set with reserved and test bits zero and latency raised to at least CL_MIN
    task automatic mrs(logic [2:0] bl, logic bo, logic [2:0] cl, logic wb);
        cmd(sdram_pkg::cmd_mrs, {4'h0, wb, 2'h0, (cl < CL_MIN) ? CL_MIN : cl, bo, bl});
    endtask
    // Refresh with banks idle and clock enable high, then idle for the row cycle
    task automatic refresh();
        cmd(sdram_pkg::cmd_ref);
        nop(T_RC);
    endtask
    // Self refresh exit: clock enable high, then idle for the row cycle
    task automatic sr_exit();
        pins(1'b1, dq_ready);
        nop(T_RC);
    endtask
endmodule

// ===== tb/tb.sv
// Bench for the DRAM core: modes, bursts, stop, mask, refresh and power states
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, cke, cs_n, ras_n, cas_n, we_n, dqm, dq_ready;
    logic dq_oe_n, suspended, burst_busy;
    logic [1:0] ba;
    logic [11:0] addr, refresh_row;
    logic [31:0] dq_in, dq_out;
    sdram_pkg::mode_t mode_reg;
    sdram_pkg::pwr_t pwr_state;
    int n_errors, cmp_count;
    // Device with a short self refresh tick
    sdram_core #(.SR_TICK(8)) dut (.core_clk, .sys_rst, .cke, .cs_n, .ras_n, .cas_n,
        .we_n, .ba, .addr, .dqm, .dq_in, .dq_out, .dq_oe_n, .dq_ready, .mode_reg,
        .refresh_row, .pwr_state, .suspended, .burst_busy);
    // Controller on the far side
    ctrl_model u_ctrl (.core_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
        .dqm, .dq_in, .dq_ready);
    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Compare and count
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // Data pattern of a column
    function automatic logic [31:0] dat(logic [7:0] c);
        return {24'h5ac3e1, c};
    endfunction
    // Close banks, program the mode, reopen bank 0
    task automatic setmode(logic [2:0] bl, logic bo, logic [2:0] cl, logic wb);
        u_ctrl.cmd(sdram_pkg::cmd_pre, 14'h400);
        u_ctrl.nop(1);
        u_ctrl.mrs(bl, bo, cl, wb);
        u_ctrl.nop(1);
        check(mode_reg, {4'h0, wb, 2'h0, cl, bo, bl});
        u_ctrl.cmd(sdram_pkg::cmd_act);
    endtask
    // Write n words from s then stop; word mk masked, jk spoils words after the first
    task automatic wr(logic [7:0] s, int n, int mk, logic jk);
        logic [7:0] c;
        logic [31:0] d;
        for (int k = 0; k < n; k++)
        begin
            c = s + 8'(k);
            d = (k == mk || (jk && k > 0)) ? ~dat(c) : dat(c);
            if (k == 0)
                u_ctrl.cmd(sdram_pkg::cmd_write, {6'h0, c}, k == mk, 1'b1, d);
            else
                u_ctrl.cmd(sdram_pkg::cmd_nop, 14'h0, k == mk, 1'b1, d);
        end
        u_ctrl.cmd(sdram_pkg::cmd_stop);
    endtask
    // Read from s, collect accepted words; stop at st, mask at mj, stall sj, suspend kj
    task automatic rd(logic [7:0] s, logic il, int cl, int n, logic ap, int st, int mj,
                      int sj, int kj);
        int w;
        int e;
        logic hold;
        logic [7:0] c;
        w = 0;
        e = 0;
        u_ctrl.cmd(sdram_pkg::cmd_read, {3'h0, ap, 2'h0, s});
        for (int j = 1; j < 40; j++)
        begin
            hold = j >= kj && j < kj + 3;
            u_ctrl.pins(!hold, !hold && !(j >= sj && j < sj + 4));
            if (j == st)
                u_ctrl.cmd(sdram_pkg::cmd_stop);
            else
                u_ctrl.cmd(sdram_pkg::cmd_nop, 14'h0, j == mj);
            if (j == kj + 1)
                check(suspended, 1'b1);
            if (dq_oe_n === 1'b0 && u_ctrl.dq_ready === 1'b1)
            begin
                if (e == mj + 2 - cl)
                    e++;
                if (w == 0)
                    check(j, cl);
                c = il ? s ^ 8'(e) : s + 8'(e);
                check(dq_out, dat(c));
                w++;
                e++;
            end
        end
        check(w, n);
    endtask
    // Verdict
    task automatic report_and_stop();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog far beyond the expected run
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        report_and_stop();
    end
    // Main sequence
    initial
    begin
        n_errors = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        u_ctrl.nop(2);
        check({mode_reg, refresh_row, dq_oe_n, suspended, burst_busy, pwr_state}, 31'h10);
        // Full page write across the column wrap, ended by stop
        setmode(3'h7, 1'b0, 3'h2, 1'b0);
        wr(8'hfc, 12, 99, 1'b0);
        // Length, order and latency cases over columns fc..07
        setmode(3'h0, 1'b0, 3'h2, 1'b0);
        rd(8'h05, 1'b0, 2, 1, 1'b0, 99, 99, 99, 99);
        setmode(3'h1, 1'b0, 3'h3, 1'b0);
        rd(8'hff, 1'b0, 3, 2, 1'b0, 99, 99, 99, 99);
        setmode(3'h2, 1'b1, 3'h2, 1'b0);
        rd(8'h06, 1'b1, 2, 4, 1'b0, 99, 99, 99, 99);
        setmode(3'h3, 1'b1, 3'h3, 1'b0);
        rd(8'h03, 1'b1, 3, 8, 1'b0, 99, 99, 99, 99);
        setmode(3'h3, 1'b0, 3'h2, 1'b0);
        rd(8'hfd, 1'b0, 2, 8, 1'b0, 99, 99, 4, 99);
        rd(8'h00, 1'b0, 2, 8, 1'b0, 99, 99, 99, 4);
        setmode(3'h7, 1'b0, 3'h2, 1'b0);
        rd(8'hfe, 1'b0, 2, 3, 1'b0, 3, 99, 99, 99);
        setmode(3'h2, 1'b0, 3'h2, 1'b0);
        rd(8'h00, 1'b0, 2, 3, 1'b0, 99, 1, 99, 99);
        rd(8'h00, 1'b0, 2, 4, 1'b1, 1, 99, 99, 99);
        // Single-word writes and a masked write leave the old words
        setmode(3'h3, 1'b0, 3'h2, 1'b1);
        wr(8'h01, 8, 99, 1'b1);
        wr(8'h05, 1, 0, 1'b0);
        rd(8'h00, 1'b0, 2, 8, 1'b0, 99, 99, 99, 99);
        // Deselect with set-mode pins, then a no-operation
        u_ctrl.cmd(sdram_pkg::cmd_desel, 14'h0033);
        u_ctrl.cmd(sdram_pkg::cmd_nop, 14'h0033);
        u_ctrl.cmd(sdram_pkg::cmd_pre, 14'h400);
        check({mode_reg, refresh_row}, 26'h223000);
        u_ctrl.refresh();
        check(refresh_row, 12'h1);
        // Power-down entry and exit
        u_ctrl.pins(1'b0, 1'b1);
        u_ctrl.nop(3);
        check(pwr_state, sdram_pkg::pwr_down);
        u_ctrl.pins(1'b1, 1'b1);
        u_ctrl.nop(3);
        check(pwr_state, sdram_pkg::pwr_run);
        // Self refresh ignores a mode set and refreshes on its own
        u_ctrl.pins(1'b0, 1'b1);
        u_ctrl.cmd(sdram_pkg::cmd_ref);
        u_ctrl.mrs(3'h1, 1'b1, 3'h3, 1'b0);
        u_ctrl.nop(40);
        check(pwr_state, sdram_pkg::pwr_self);
        check(mode_reg, 14'h0223);
        check(refresh_row >= 12'h4 && refresh_row <= 12'h8, 1'b1);
        u_ctrl.sr_exit();
        check(pwr_state, sdram_pkg::pwr_run);
        // Reset in mid-run, then bank 1 writes must leave bank 0 alone
        sys_rst <= 1'b1;
        u_ctrl.nop(2);
        sys_rst <= 1'b0;
        u_ctrl.nop(1);
        check({mode_reg, refresh_row, dq_oe_n, suspended, burst_busy, pwr_state}, 31'h10);
        setmode(3'h1, 1'b0, 3'h2, 1'b0);
        u_ctrl.cmd(sdram_pkg::cmd_act, 14'h1000);
        u_ctrl.cmd(sdram_pkg::cmd_write, 14'h1005, 1'b0, 1'b1, ~dat(8'h05));
        u_ctrl.cmd(sdram_pkg::cmd_nop, 14'h0, 1'b0, 1'b1, ~dat(8'h06));
        rd(8'h05, 1'b0, 2, 2, 1'b0, 99, 99, 99, 99);
        report_and_stop();
    end
endmodule
